// [rtl/coil_drive_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef COIL_DRIVE_REGS_SVH
`define COIL_DRIVE_REGS_SVH

// ==========================================================================
// Register map (byte addresses)
`define REG_CTRL        8'h00
`define REG_POSITION    8'h04
`define REG_OFFSET      8'h08
`define REG_ILIMIT      8'h0c
`define REG_AMPLITUDE   8'h10
`define REG_STATUS      8'h14
`define REG_FAULT       8'h18
`define REG_PHASE       8'h1c

// ==========================================================================
// Fields and reset values
`define CTRL_ENABLE_BIT   0
`define FLT_OVERTEMP_BIT  0
`define FLT_OVERCUR_A_BIT 1
`define FLT_OVERCUR_B_BIT 2
`define FLT_OPEN_A_BIT    3
`define FLT_OPEN_B_BIT    4
`define ILIMIT_RESET      12'h8ca
`define AMPLITUDE_RESET   8'hff

// ==========================================================================
// Timing
`define CLK_PERIOD_NS     10
`define PWM_FREQ_HZ       20000
`define PWM_PERIOD_CYC    (1000000000 / (`PWM_FREQ_HZ * `CLK_PERIOD_NS))
`define TICK_PERIOD_NS    100000
`define TICK_CYC          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define DIAG_TICKS        10

// ==========================================================================
// Duty, current and phase scaling
`define DUTY_MIN_PCT      5
`define DUTY_MAX_PCT      95
`define DUTY_MID_PCT      50
`define DUTY_MIN   ((`PWM_PERIOD_CYC * `DUTY_MIN_PCT) / 100)
`define DUTY_MAX   ((`PWM_PERIOD_CYC * `DUTY_MAX_PCT) / 100)
`define DUTY_MID   ((`PWM_PERIOD_CYC * `DUTY_MID_PCT) / 100)
`define I_MAX_MA          2250
`define SENSE_OFFSET_MV   2496
`define SENSE_GAIN_UV_MA  499
`define SENSE_RECIP  ((1024 * 1000) / `SENSE_GAIN_UV_MA)
`define OPEN_MA           100
`define OPEN_DELTA        1000
`define MAX_RATE_RADPS    70
`define PHASE_STEP_MAX \
  ((64'd`MAX_RATE_RADPS * 64'd65536 * 64'd1000 * 64'd`TICK_PERIOD_NS) \
   / (64'd6283 * 64'd1000000000))
`define ELEC_REV_X2       125

`endif

// [rtl/coil_drive_pkg.sv]
// Types shared by the coil drive logic
package coil_drive_pkg;
  typedef logic signed [13:0] duty_t;
  typedef logic        [21:0] phase_t;
  typedef enum logic [1:0] {
    DIAG_IDLE  = 2'b00,
    DIAG_COILA = 2'b01,
    DIAG_COILB = 2'b11
  } diag_state_t;
endpackage

// [rtl/sine_microstep_coil_drive.sv]
// Sine microstep two-coil stepper drive with register port
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "coil_drive_regs.svh"

// Operation
// - Enable held high, brake held low
// - Duty clamped between five and ninety-five percent
// - Fifty percent duty means zero current
// - Direction high first, then low
// - Coil B lags coil A quarter period
// - One electrical period spans four steps
// - Full command equals 1.25 motor rotations
// - Electrical phase rate limited near 70 rad/s
// - Programmable peak current, at most 2.25 A
// - Position loop updates every 0.1 ms tick
// - Diagnostics slower, split into portions
// - Low overtemp input means thermal alarm
// - Sense value to current: offset plus gain
// - Each winding limited and checked separately
// - Calibration offset added to electrical phase
// - Offset full scale is one electrical revolution
module sine_microstep_coil_drive #(
  parameter int TICK_CYCLES = `TICK_CYC
) (
  input  wire logic        MCLK,                 // System clock, 100 MHz
  input  wire logic        RSTN,                 // Async reset, active low
  input  wire logic [7:0]  ADDR,                 // Register byte address
  input  wire logic [31:0] WDATA,                // Write data
  input  wire logic        WE,                   // Write strobe
  input  wire logic        RE,                   // Read strobe
  output logic      [31:0] RDATA,                // Read data, cycle after RE
  input  wire logic [11:0] COIL_CURRENT_SENSE_A, // Coil A sense, mV
  input  wire logic [11:0] COIL_CURRENT_SENSE_B, // Coil B sense, mV
  input  wire logic        OVERTEMP_WARNING_N,   // Driver warning, low=hot
  output logic             COIL_DUTY_A,          // Bridge A direction
  output logic             COIL_DUTY_B,          // Bridge B direction
  output logic             BRIDGE_ENABLE_LINE_A, // Bridge A enable
  output logic             BRIDGE_ENABLE_LINE_B, // Bridge B enable
  output logic             BRIDGE_BRAKE_LINE_A,  // Bridge A brake
  output logic             BRIDGE_BRAKE_LINE_B   // Bridge B brake
);

  localparam logic [12:0] PWM_LAST = 13'(`PWM_PERIOD_CYC - 1);
  localparam coil_drive_pkg::duty_t D_MIN = 14'(`DUTY_MIN);
  localparam coil_drive_pkg::duty_t D_MAX = 14'(`DUTY_MAX);
  localparam coil_drive_pkg::duty_t D_MID = 14'(`DUTY_MID);
  localparam logic [21:0] STEP_MAX = 22'(`PHASE_STEP_MAX);
  localparam logic [7:0] QTAB [0:16] = '{
    8'h00, 8'h19, 8'h32, 8'h4a, 8'h62, 8'h78, 8'h8e, 8'ha2, 8'hb4,
    8'hc5, 8'hd4, 8'he1, 8'hec, 8'hf4, 8'hfa, 8'hfe, 8'hff};

  // ========================================================================
  // Register file
  logic        enable_ff;
  logic [15:0] position_ff;
  logic [15:0] offset_ff;
  logic [11:0] ilimit_ff;
  logic [7:0]  amplitude_ff;
  logic [4:0]  fault_ff;
  logic [4:0]  fault_set;
  coil_drive_pkg::phase_t phase_ff;
  coil_drive_pkg::duty_t  duty_a_ff;
  coil_drive_pkg::duty_t  duty_b_ff;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      enable_ff    <= 1'b0;
      position_ff  <= 16'h0000;
      offset_ff    <= 16'h0000;
      ilimit_ff    <= `ILIMIT_RESET;
      amplitude_ff <= `AMPLITUDE_RESET;
    end
    else if (WE)
    begin
      unique case (ADDR)
        `REG_CTRL:      enable_ff    <= WDATA[`CTRL_ENABLE_BIT];
        `REG_POSITION:  position_ff  <= WDATA[15:0];
        `REG_OFFSET:    offset_ff    <= WDATA[15:0];
        `REG_ILIMIT:
          ilimit_ff <= (WDATA[11:0] > 12'(`I_MAX_MA)) ? 12'(`I_MAX_MA)
                                                       : WDATA[11:0];
        `REG_AMPLITUDE: amplitude_ff <= WDATA[7:0];
        default: ;
      endcase
    end
  end

  // Set wins over write-one-to-clear so no event is lost
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      fault_ff <= 5'h00;
    else if (WE && ADDR == `REG_FAULT)
      fault_ff <= (fault_ff & ~WDATA[4:0]) | fault_set;
    else
      fault_ff <= fault_ff | fault_set;
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 32'h0000_0000;
    else if (RE)
    begin
      unique case (ADDR)
        `REG_CTRL:      RDATA <= {31'h0, enable_ff};
        `REG_POSITION:  RDATA <= {16'h0, position_ff};
        `REG_OFFSET:    RDATA <= {16'h0, offset_ff};
        `REG_ILIMIT:    RDATA <= {20'h0, ilimit_ff};
        `REG_AMPLITUDE: RDATA <= {24'h0, amplitude_ff};
        `REG_STATUS:    RDATA <= {2'h0, 14'(duty_b_ff), 2'h0,
                                  14'(duty_a_ff)};
        `REG_FAULT:     RDATA <= {27'h0, fault_ff};
        `REG_PHASE:     RDATA <= {10'h0, phase_ff};
        default:        RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Loop tick and PWM carrier
  logic [13:0] tick_cnt_ff;
  logic        tick_ff;
  logic [12:0] pwm_cnt_ff;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tick_cnt_ff <= 14'h0000;
      tick_ff     <= 1'b0;
    end
    else if (tick_cnt_ff == 14'(TICK_CYCLES - 1))
    begin
      tick_cnt_ff <= 14'h0000;
      tick_ff     <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 14'h0001;
      tick_ff     <= 1'b0;
    end
  end

  // 5000 counts per period gives over 12 bits of duty resolution
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      pwm_cnt_ff <= 13'h0000;
    else if (pwm_cnt_ff == PWM_LAST)
      pwm_cnt_ff <= 13'h0000;
    else
      pwm_cnt_ff <= pwm_cnt_ff + 13'h0001;
  end

  // ========================================================================
  // Phase tracking with rate limit
  logic [22:0] target_prod;
  coil_drive_pkg::phase_t target;
  logic [15:0] elec_angle;

  assign target_prod = 23'(position_ff) * 23'(`ELEC_REV_X2);
  assign target      = target_prod[22:1];
  assign elec_angle  = phase_ff[15:0] + offset_ff;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      phase_ff <= 22'h000000;
    else if (tick_ff && enable_ff)
    begin
      if (target > phase_ff + STEP_MAX)
        phase_ff <= phase_ff + STEP_MAX;
      else if (phase_ff > target + STEP_MAX)
        phase_ff <= phase_ff - STEP_MAX;
      else
        phase_ff <= target;
    end
  end

  // ========================================================================
  // Sine table and coil demand
  function automatic logic signed [8:0] sine_of(input logic [5:0] idx);
    logic [7:0] mag;
    mag = idx[4] ? QTAB[5'd16 - {1'b0, idx[3:0]}] : QTAB[{1'b0, idx[3:0]}];
    sine_of = idx[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  function automatic coil_drive_pkg::duty_t demand_of(
      input logic signed [8:0] s, input logic [7:0] amp);
    logic signed [21:0] p;
    logic signed [21:0] p9;
    coil_drive_pkg::duty_t d;
    p  = s * $signed({1'b0, amp});
    p9 = (p <<< 3) + p;
    d  = D_MID + 14'(p9 >>> 8);
    if (d < D_MIN)
      d = D_MIN;
    else if (d > D_MAX)
      d = D_MAX;
    demand_of = d;
  endfunction

  function automatic logic [12:0] current_ma(input logic [11:0] mv);
    logic signed [13:0] diff;
    logic signed [26:0] prod;
    logic signed [16:0] ma;
    diff = $signed({2'b00, mv}) - 14'sd`SENSE_OFFSET_MV;
    prod = diff * $signed(14'(`SENSE_RECIP));
    ma   = 17'(prod >>> 10);
    current_ma = (ma < 0) ? 13'(-ma) : 13'(ma);
  endfunction

  logic signed [8:0] sin_a;
  logic signed [8:0] sin_b;
  logic [7:0]  amp_eff;
  logic [12:0] cur_a;
  logic [12:0] cur_b;
  coil_drive_pkg::duty_t dem_a;
  coil_drive_pkg::duty_t dem_b;

  assign sin_a   = sine_of(elec_angle[15:10]);
  assign sin_b   = sine_of(elec_angle[15:10] - 6'h10);
  assign amp_eff = amplitude_ff;
  assign dem_a   = demand_of(sin_a, amp_eff);
  assign dem_b   = demand_of(sin_b, amp_eff);
  assign cur_a   = current_ma(COIL_CURRENT_SENSE_A);
  assign cur_b   = current_ma(COIL_CURRENT_SENSE_B);

  // Winding over its limit drops to zero drive for one tick
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      duty_a_ff <= D_MID;
      duty_b_ff <= D_MID;
    end
    else if (!enable_ff)
    begin
      duty_a_ff <= D_MID;
      duty_b_ff <= D_MID;
    end
    else if (tick_ff)
    begin
      duty_a_ff <= (cur_a > {1'b0, ilimit_ff}) ? D_MID : dem_a;
      duty_b_ff <= (cur_b > {1'b0, ilimit_ff}) ? D_MID : dem_b;
    end
  end

  // ========================================================================
  // Bridge outputs; duty latched at period start to avoid runt pulses
  coil_drive_pkg::duty_t live_a_ff;
  coil_drive_pkg::duty_t live_b_ff;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      live_a_ff <= D_MID;
      live_b_ff <= D_MID;
    end
    else if (pwm_cnt_ff == PWM_LAST)
    begin
      live_a_ff <= duty_a_ff;
      live_b_ff <= duty_b_ff;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      COIL_DUTY_A          <= 1'b0;
      COIL_DUTY_B          <= 1'b0;
      BRIDGE_ENABLE_LINE_A <= 1'b0;
      BRIDGE_ENABLE_LINE_B <= 1'b0;
      BRIDGE_BRAKE_LINE_A  <= 1'b0;
      BRIDGE_BRAKE_LINE_B  <= 1'b0;
    end
    else
    begin
      COIL_DUTY_A          <= 14'(pwm_cnt_ff) < live_a_ff;
      COIL_DUTY_B          <= 14'(pwm_cnt_ff) < live_b_ff;
      BRIDGE_ENABLE_LINE_A <= 1'b1;
      BRIDGE_ENABLE_LINE_B <= 1'b1;
      BRIDGE_BRAKE_LINE_A  <= 1'b0;
      BRIDGE_BRAKE_LINE_B  <= 1'b0;
    end
  end

  // ========================================================================
  // Slow diagnostics, one winding per portion
  coil_drive_pkg::diag_state_t diag_ff;
  logic [3:0] diag_cnt_ff;
  logic       open_a;
  logic       open_b;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      diag_cnt_ff <= 4'h0;
      diag_ff     <= coil_drive_pkg::DIAG_IDLE;
    end
    else if (tick_ff)
    begin
      unique case (diag_ff)
        coil_drive_pkg::DIAG_IDLE:
          if (diag_cnt_ff == 4'(`DIAG_TICKS - 1))
          begin
            diag_cnt_ff <= 4'h0;
            diag_ff     <= coil_drive_pkg::DIAG_COILA;
          end
          else
            diag_cnt_ff <= diag_cnt_ff + 4'h1;
        coil_drive_pkg::DIAG_COILA:
          diag_ff <= coil_drive_pkg::DIAG_COILB;
        coil_drive_pkg::DIAG_COILB:
          diag_ff <= coil_drive_pkg::DIAG_IDLE;
        default:
          diag_ff <= coil_drive_pkg::DIAG_IDLE;
      endcase
    end
  end

  // Open coil: strong demand yet almost no current
  assign open_a = (duty_a_ff - D_MID > 14'sd`OPEN_DELTA ||
                   D_MID - duty_a_ff > 14'sd`OPEN_DELTA) &&
                  cur_a < 13'(`OPEN_MA);
  assign open_b = (duty_b_ff - D_MID > 14'sd`OPEN_DELTA ||
                   D_MID - duty_b_ff > 14'sd`OPEN_DELTA) &&
                  cur_b < 13'(`OPEN_MA);

  always_comb
  begin
    fault_set = 5'h00;
    fault_set[`FLT_OVERTEMP_BIT] = !OVERTEMP_WARNING_N;
    fault_set[`FLT_OVERCUR_A_BIT] = tick_ff && enable_ff &&
                                    cur_a > {1'b0, ilimit_ff};
    fault_set[`FLT_OVERCUR_B_BIT] = tick_ff && enable_ff &&
                                    cur_b > {1'b0, ilimit_ff};
    fault_set[`FLT_OPEN_A_BIT] = tick_ff && enable_ff && open_a &&
                      diag_ff == coil_drive_pkg::DIAG_COILA;
    fault_set[`FLT_OPEN_B_BIT] = tick_ff && enable_ff && open_b &&
                      diag_ff == coil_drive_pkg::DIAG_COILB;
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  sequence s_period_end;
    pwm_cnt_ff == PWM_LAST;
  endsequence

  sequence s_period_start_high;
    ##1 (pwm_cnt_ff == 13'h0000) ##1 COIL_DUTY_A;
  endsequence

  // Lines still show reset levels on the first edge after release
  AST_BRIDGE_STATIC: assert property (
    $past(RSTN) |->
    BRIDGE_ENABLE_LINE_A && BRIDGE_ENABLE_LINE_B &&
    !BRIDGE_BRAKE_LINE_A && !BRIDGE_BRAKE_LINE_B)
    else $error("Bridge enable or brake not at fixed level");

  AST_DUTY_CLAMP: assert property (
    live_a_ff >= D_MIN && live_a_ff <= D_MAX &&
    live_b_ff >= D_MIN && live_b_ff <= D_MAX)
    else $error("Duty outside clamp range");

  AST_IDLE_MID: assert property (
    !enable_ff ##1 !enable_ff |=> duty_a_ff == D_MID && duty_b_ff == D_MID)
    else $error("Duty not at midpoint while disabled");

  AST_DIR_FIRST: assert property (
    s_period_end and (live_a_ff > 14'sd1) |-> s_period_start_high)
    else $error("Direction not high at start of period");

  AST_RATE_LIMIT: assert property (
    tick_ff |=> (phase_ff - $past(phase_ff) <= STEP_MAX ||
                 $past(phase_ff) - phase_ff <= STEP_MAX))
    else $error("Phase moved faster than rate limit");

  AST_PHASE_HOLD: assert property (
    !tick_ff |=> $stable(phase_ff))
    else $error("Phase changed outside loop tick");

  AST_ILIMIT_MAX: assert property (
    ilimit_ff <= 12'(`I_MAX_MA))
    else $error("Current limit above maximum");

  AST_OVERTEMP: assert property (
    !OVERTEMP_WARNING_N |=> fault_ff[`FLT_OVERTEMP_BIT])
    else $error("Thermal alarm not recorded");

  AST_QUADRATURE: assert property (
    elec_angle[15:10] == 6'h00 |-> sin_a == 9'sd0 && sin_b == -9'sd255)
    else $error("Coil B not a quarter period behind coil A");

  AST_DIAG_ORDER: assert property (
    tick_ff && diag_ff == coil_drive_pkg::DIAG_COILA
      |=> diag_ff == coil_drive_pkg::DIAG_COILB)
    else $error("Diagnostic portions out of order");

endmodule // sine_microstep_coil_drive
`default_nettype wire

// [tb/bridge_pair_model.sv]
// Behavioural pair of H-bridges with coil current sense
`timescale 1ns/1ps
`default_nettype none
module bridge_pair_model (
  input  wire logic        mclk,     // System clock
  input  wire logic        rstn,     // Reset, active low
  input  wire logic [1:0]  dir,      // Direction lines, coil B in bit 1
  input  wire logic [1:0]  en,       // Enable lines
  input  wire logic [1:0]  brk,      // Brake lines
  input  wire logic [1:0]  open_w,   // Bench-commanded open winding
  input  wire logic        hot,      // Bench-commanded thermal warning
  output logic      [11:0] sense_a,  // Coil A sense, mV
  output logic      [11:0] sense_b,  // Coil B sense, mV
  output logic             ot_n,     // Thermal warning, low when hot
  output logic      [12:0] hi_a,     // High cycles, last coil A period
  output logic      [12:0] hi_b,     // High cycles, last coil B period
  output logic      [12:0] per_a,    // Length of last coil A period
  output logic             done,     // Coil A period just closed
  output int               pins_bad  // Cycles with enable or brake wrong
);
  logic [12:0] cnt [2];
  logic [12:0] run [2];
  logic [12:0] hi  [2];
  logic [1:0]  dir_d;
  logic        live;

  // ==========================================================================
  // Period measure
  // A period opens on each rising edge, since source-one comes first
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_d    <= 2'b00;
      live     <= 1'b0;
      done     <= 1'b0;
      per_a    <= 13'h0;
      pins_bad <= 0;
      for (int i = 0; i < 2; i++)
      begin
        cnt[i] <= 13'h0;
        run[i] <= 13'h0;
        hi[i]  <= 13'h9c4;
      end
    end
    else
    begin
      dir_d <= dir;
      live  <= 1'b1;
      done  <= dir[0] & ~dir_d[0];
      if (dir[0] & ~dir_d[0])
        per_a <= cnt[0];
      for (int i = 0; i < 2; i++)
        if (dir[i] & ~dir_d[i])
        begin
          hi[i]  <= run[i];
          cnt[i] <= 13'h1;
          run[i] <= 13'h1;
        end
        else
        begin
          cnt[i] <= cnt[i] + 13'h1;
          run[i] <= run[i] + {12'h0, dir[i]};
        end
      // Skip first edge: the lines only rise on it
      if (live && (en !== 2'b11 || brk !== 2'b00))
        pins_bad <= pins_bad + 1;
    end
  end

  // ==========================================================================
  // Sense and warning
  // One mA per count off midpoint; current follows last full period
  function automatic logic [11:0] to_mv(input logic [12:0] h,
                                        input logic op);
    int ma;
    ma = int'(h) - 2500;
    if (op)
      return 12'h9c0;
    return 12'(2496 + (ma * 499) / 1000);
  endfunction

  assign hi_a    = hi[0];
  assign hi_b    = hi[1];
  assign sense_a = to_mv(hi[0], open_w[0]);
  assign sense_b = to_mv(hi[1], open_w[1]);
  assign ot_n    = ~hot;
endmodule // bridge_pair_model
`default_nettype wire

// [tb/test_sine_microstep_coil_drive.sv]
// Self-checking bench for the sine microstep coil drive
`timescale 1ns/1ps
`default_nettype none
`include "coil_drive_regs.svh"
module test_sine_microstep_coil_drive;
  localparam int TICK = 100;
  typedef struct {logic [31:0] lo; logic [31:0] hi; logic [31:0] mask;} rexp_t;
  typedef struct {logic [12:0] a; logic [12:0] b;} dexp_t;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        re_d = 1'b0;
  logic        take = 1'b0;
  logic [1:0]  open_w = 2'b00;
  logic        hot = 1'b0;
  logic [31:0] rdata;
  logic [11:0] sense_a, sense_b;
  logic [1:0]  dir, en, brk;
  logic        ot_n, done;
  logic [12:0] hi_a, hi_b, per_a;
  logic [31:0] rnd;
  int          pins_bad;
  int          bad_count = 0;
  int          n_tests = 0;
  rexp_t       rq[$];
  dexp_t       dq[$];
  logic [15:0] offs [3] = '{16'h8000, 16'hc000, 16'h4000};
  logic [12:0] ea   [3] = '{13'h9c4, 13'h0fa, 13'h128e};
  logic [12:0] eb   [3] = '{13'h128e, 13'h9c4, 13'h9c4};

  always #5 mclk = ~mclk;

  sine_microstep_coil_drive #(.TICK_CYCLES(TICK))
    sine_microstep_coil_drive_inst (
    .MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
    .RDATA(rdata), .COIL_CURRENT_SENSE_A(sense_a),
    .COIL_CURRENT_SENSE_B(sense_b), .OVERTEMP_WARNING_N(ot_n),
    .COIL_DUTY_A(dir[0]), .COIL_DUTY_B(dir[1]),
    .BRIDGE_ENABLE_LINE_A(en[0]), .BRIDGE_ENABLE_LINE_B(en[1]),
    .BRIDGE_BRAKE_LINE_A(brk[0]), .BRIDGE_BRAKE_LINE_B(brk[1]));

  bridge_pair_model bridge_pair_model_inst (
    .mclk(mclk), .rstn(rstn), .dir(dir), .en(en), .brk(brk),
    .open_w(open_w), .hot(hot), .sense_a(sense_a), .sense_b(sense_b),
    .ot_n(ot_n), .hi_a(hi_a), .hi_b(hi_b), .per_a(per_a), .done(done),
    .pins_bad(pins_bad));

  // ==========================================================================
  // Compare and closing
  task automatic miss(input string what);
    bad_count++;
    $display("mismatch at %0t: %s", $time, what);
  endtask

  task automatic cmp_reg(input rexp_t e, input logic [31:0] got);
    logic [31:0] v;
    v = got & e.mask;
    n_tests++;
    if ((v >= e.lo && v <= e.hi) !== 1'b1)
      miss($sformatf("register read %h", got));
  endtask

  task automatic cmp_duty(input dexp_t e);
    n_tests++;
    if (hi_a !== e.a || hi_b !== e.b || per_a !== 13'h1388)
      miss($sformatf("duty %0d %0d period %0d", hi_a, hi_b, per_a));
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Bus and duty tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge mclk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] lo,
                    input logic [31:0] hi, input logic [31:0] mask);
    rq.push_back('{lo, hi, mask});
    @(posedge mclk);
    addr <= a;
    re   <= 1'b1;
    @(posedge mclk);
    re <= 1'b0;
  endtask

  // Third period end after a change is the first wholly new one
  task automatic chk_duty(input logic [12:0] a, input logic [12:0] b);
    int k;
    repeat (2)
    begin
      k = 0;
      do @(posedge mclk); while (done !== 1'b1 && ++k < 6000);
    end
    dq.push_back('{a, b});
    take <= 1'b1;
    k = 0;
    while (dq.size() != 0 && k < 6000)
    begin
      @(posedge mclk);
      k++;
    end
    take <= 1'b0;
    if (dq.size() != 0)
    begin
      miss("no coil period seen");
      dq.delete();
    end
  endtask

  always @(posedge mclk)
  begin
    re_d <= re;
    if (re_d)
      cmp_reg(rq.pop_front(), rdata);
    if (take && done && dq.size() != 0)
      cmp_duty(dq.pop_front());
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    rnd = $urandom(32'h1462);
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rd(`REG_CTRL, 32'h0, 32'h0, 32'hffffffff);
    rd(`REG_ILIMIT, 32'h8ca, 32'h8ca, 32'hffffffff);
    rd(`REG_AMPLITUDE, 32'hff, 32'hff, 32'hffffffff);
    rd(8'h20, 32'h0, 32'h0, 32'hffffffff);
    wr(`REG_ILIMIT, 32'hfff);
    rd(`REG_ILIMIT, 32'h8ca, 32'h8ca, 32'hffffffff);
    chk_duty(13'h9c4, 13'h9c4);
    wr(`REG_CTRL, 32'h1);
    chk_duty(13'h9c4, 13'h0fa);
    rd(`REG_STATUS, 32'h00fa09c4, 32'h00fa09c4, 32'hffffffff);
    for (int i = 0; i < 3; i++)
    begin
      wr(`REG_OFFSET, {16'h0, offs[i]});
      chk_duty(ea[i], eb[i]);
    end
    // Model current lags a duty step, so stale open flags are cleared
    wr(`REG_FAULT, 32'h1f);
    open_w <= 2'b01;
    repeat (2500) @(posedge mclk);
    rd(`REG_FAULT, 32'h8, 32'h8, 32'h18);
    open_w <= 2'b00;
    wr(`REG_FAULT, 32'h1f);
    rd(`REG_FAULT, 32'h0, 32'h0, 32'h1f);
    hot <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(`REG_FAULT, 32'h1, 32'h1, 32'h1);
    hot <= 1'b0;
    wr(`REG_FAULT, 32'h1);
    rd(`REG_FAULT, 32'h0, 32'h0, 32'h1);
    wr(`REG_ILIMIT, 32'h1f4);
    repeat (300) @(posedge mclk);
    rd(`REG_FAULT, 32'h2, 32'h2, 32'h6);
    wr(`REG_ILIMIT, 32'h8ca);
    rnd = $urandom & 32'hff;
    wr(`REG_AMPLITUDE, rnd);
    rd(`REG_AMPLITUDE, rnd, rnd, 32'hff);
    wr(`REG_OFFSET, 32'h0);
    wr(`REG_POSITION, 32'h10);
    repeat (20 * TICK) @(posedge mclk);
    rd(`REG_PHASE, 32'd1000, 32'd1000, 32'h3fffff);
    wr(`REG_POSITION, 32'hffff);
    repeat (10 * TICK) @(posedge mclk);
    rd(`REG_PHASE, 32'd1657, 32'd1803, 32'h3fffff);
    repeat (4) @(posedge mclk);
    n_tests++;
    if (pins_bad !== 0)
      miss("bridge enable or brake line moved");
    wrap_up();
  end

  // Five duty checks of up to three periods each set the span
  initial
  begin
    repeat (95000) @(posedge mclk);
    miss("watchdog expired");
    wrap_up();
  end
endmodule // test_sine_microstep_coil_drive
`default_nettype wire
